// [common/haptic_cfg.svh]
`ifndef HAPTIC_CFG_SVH
`define HAPTIC_CFG_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define CFG_ADDR_W          8
`define ACT_LOOP_CFG_OFF    8'h08

// ----------------------------------------
// field positions of actuator_loop_config
// ----------------------------------------
`define FLD_ACT_TYPE        7
`define FLD_OPEN_LOOP       6
`define FLD_HYBRID          5
`define FLD_OL_AUTOBRAKE    4
`define FLD_STBY_BRAKE      3
`define FLD_SLOPE_CHECK     2
`define FLD_RSVD_HI         1
`define FLD_RSVD_LO         0

// ----------------------------------------
// reset values
// ----------------------------------------
`define ACT_LOOP_CFG_RST    8'h88

// ----------------------------------------
// trigger pin function codes
// ----------------------------------------
`define TRIG_FN_LEVEL_EN    2'h1

// ----------------------------------------
// drive data and slope check
// ----------------------------------------
`define SAMPLE_W_DEF        8
`define SLOPE_THRESH_DEF    32

`endif

// [common/haptic_pkg.sv]
package haptic_pkg;

    // ----------------------------------------
    // playback sequencing states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PLAY,
        ST_MOTION_CHECK,
        ST_BRAKE,
        ST_STANDBY
    } play_state_t;

endpackage : haptic_pkg

// [dv/actuator_model.sv]
`timescale 1ns/1ps
module actuator_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       standby_brake,
    input  wire logic       moving,
    input  wire logic [7:0] brk_len,
    output logic            motion_detect,
    output logic            brake_done
);
    int cnt;
    // braking lasts brk_len+1 cycles, so stops can be prompt or slow
    always @(posedge clk or posedge rst) begin
        if (rst) cnt <= 0;
        else if (standby_brake) cnt <= cnt + 1;
        else cnt <= 0;
    end
    assign brake_done    = standby_brake && cnt >= int'(brk_len);
    assign motion_detect = moving && !brake_done;
endmodule : actuator_model

// [dv/haptic_checker_assertions.sv]
`timescale 1ns/1ps
module haptic_checker #(
    parameter int SAMPLE_W     = 8,
    parameter int SLOPE_THRESH = 32
) (
    input logic                       clk,
    input logic                       rst,
    input logic [7:0]                 reg_addr,
    input logic [7:0]                 reg_wdata,
    input logic                       reg_wr,
    input logic                       reg_rd,
    input logic [7:0]                 reg_rdata,
    input logic                       sample_valid,
    input logic signed [SAMPLE_W-1:0] sample,
    input logic                       idle_timeout,
    input logic                       motion_detect,
    input logic                       brake_done,
    input logic [1:0]                 trigger_pin_function,
    input logic                       trigger_irq_pin,
    input logic                       actuator_type_sel,
    input logic                       closed_loop_drive,
    input logic                       openloop_brake,
    input logic                       standby_brake,
    input logic                       in_standby,
    input logic                       playing
);
    // ----
    // shadow of the config byte and of the last sample
    // ----
    logic [7:0]                 cfg_r;
    logic signed [SAMPLE_W-1:0] prev_r;
    int                         dif;
    logic                       big;
    assign dif = int'(sample) - int'(prev_r);
    assign big = dif >= SLOPE_THRESH || dif <= -SLOPE_THRESH;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_r  <= 8'h88;
            prev_r <= '0;
        end else begin
            if (reg_wr && reg_addr == 8'h08) cfg_r <= reg_wdata;
            if (sample_valid) prev_r <= sample;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_read_back: assert property (reg_rd && reg_addr == 8'h08 |=> reg_rdata == cfg_r)
        else $error("config read back differs");
    a_read_quiet: assert property (!($past(reg_rd) && $past(reg_addr) == 8'h08)
        |-> reg_rdata == 8'h00) else $error("read data not zero");
    a_type_mirror: assert property (reg_wr && reg_addr == 8'h08
        |=> actuator_type_sel == $past(reg_wdata[7])) else $error("actuator type wrong");
    a_ol_brake: assert property (sample_valid && sample <= 0 && cfg_r[6] && cfg_r[4]
        |-> ##2 closed_loop_drive && openloop_brake) else $error("no open-loop brake");
    a_ol_positive: assert property (sample_valid && sample > 0 && cfg_r[6]
        |-> ##2 !closed_loop_drive && !openloop_brake) else $error("positive not open");
    a_closed_hold: assert property ((!cfg_r[6] && !cfg_r[5]) [*3] |-> closed_loop_drive)
        else $error("full closed loop lost");
    a_hybrid_step: assert property (sample_valid && cfg_r[6:5] == 2'b01 && cfg_r[2]
        |-> ##2 closed_loop_drive == $past(big, 2)) else $error("slope decision wrong");
    a_stby_direct: assert property (playing && idle_timeout && !cfg_r[3]
        |=> in_standby && !standby_brake) else $error("standby not direct");
    a_stby_motion: assert property (playing && idle_timeout && cfg_r[3]
        |=> !in_standby && !standby_brake ##1 standby_brake == $past(motion_detect)
        && in_standby == !$past(motion_detect)) else $error("motion check wrong");
    a_brake_end: assert property (standby_brake && brake_done
        |=> !standby_brake && in_standby) else $error("brake end wrong");
    a_trig_level: assert property (playing && trigger_pin_function == 2'h1
        && $fell(trigger_irq_pin) && !cfg_r[3] |-> ##[1:6] in_standby)
        else $error("pin release ignored");
endmodule : haptic_checker

bind haptic_loop_brake_config haptic_checker #(.SAMPLE_W(SAMPLE_W),
    .SLOPE_THRESH(SLOPE_THRESH)) u_chk (.*);

// [dv/haptic_loop_brake_config_tb.sv]
`timescale 1ns/1ps
module haptic_loop_brake_config_tb;
    logic              clk, rst, reg_wr, reg_rd, play_start, sample_valid, idle_timeout;
    logic              motion_detect, brake_done, trigger_irq_pin, moving;
    logic              actuator_type_sel, closed_loop_drive, openloop_brake;
    logic              standby_brake, in_standby, playing;
    logic [7:0]        reg_addr, reg_wdata, reg_rdata, brk_len, d;
    logic [1:0]        trigger_pin_function;
    logic signed [7:0] sample;
    int                error_cnt = 0, tests_run = 0, cyc = 0;

    haptic_loop_brake_config #(.SLOPE_THRESH(32)) dut (.*);
    actuator_model act (.clk(clk), .rst(rst), .standby_brake(standby_brake), .moving(moving),
        .brk_len(brk_len), .motion_detect(motion_detect), .brake_done(brake_done));

    // ----
    // clock and hang guard
    // ----
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic chk(string n, logic [7:0] got, logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, exp, got);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic smp(logic [7:0] v, logic c, logic b);
        @(posedge clk);
        sample       <= v;
        sample_valid <= 1'b1;
        @(posedge clk);
        sample_valid <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("closed", closed_loop_drive, c);
        chk("olbrake", openloop_brake, b);
    endtask : smp
    // play, then ask for standby; eb is the expected brake pulse,
    // w is the wait in cycles, -1 skips it
    task automatic stby(logic m, logic eb, logic [7:0] len, int w);
        int   i;
        logic sb;
        sb = 1'b0;
        @(posedge clk);
        moving     <= m;
        brk_len    <= len;
        play_start <= 1'b1;
        @(posedge clk);
        play_start   <= 1'b0;
        idle_timeout <= 1'b1;
        #1;
        chk("playing", playing, 1);
        @(posedge clk);
        idle_timeout <= 1'b0;
        #1;
        for (i = 0; i < 30 && !in_standby; i++) begin
            sb |= standby_brake;
            @(posedge clk);
            #1;
        end
        chk("standby", in_standby, 1);
        chk("braked", sb, eb);
        if (w >= 0) chk("wait", i[7:0], w[7:0]);
    endtask : stby
    task automatic t_regs();
        chk("type", actuator_type_sel, 1);
        chk("closed", closed_loop_drive, 1);
        chk("idle", {in_standby, playing, standby_brake, openloop_brake}, 0);
        rd(8'h08);
        chk("cfg", d, 8'h88);
        wr(8'h08, 8'h03);
        rd(8'h08);
        chk("cfg", d, 8'h03);
        chk("type", actuator_type_sel, 0);
        chk("closed", closed_loop_drive, 1);
        wr(8'h09, 8'hFF);
        rd(8'h09);
        chk("unmapped", d, 8'h00);
    endtask : t_regs
    task automatic t_open();
        wr(8'h08, 8'hD0); // type set first, brake enabled as trusted
        smp(8'hFD, 1, 1);
        smp(8'h00, 1, 1);
        smp(8'h05, 0, 0);
        smp(8'h80, 1, 1);
        wr(8'h08, 8'hC0);
        smp(8'hFD, 0, 0);
    endtask : t_open
    task automatic t_hybrid();
        wr(8'h08, 8'hA4);
        smp(8'h00, 0, 0);
        smp(8'h1F, 0, 0);
        smp(8'h3F, 1, 0);
        smp(8'h1F, 1, 0);
        smp(8'h20, 0, 0);
        wr(8'h08, 8'hA0);
        smp(8'h21, 1, 0);
        wr(8'h08, 8'h84);
        smp(8'h22, 1, 0);
    endtask : t_hybrid
    task automatic t_standby();
        wr(8'h08, 8'h80);
        stby(1'b1, 1'b0, 8'h00, 0);
        wr(8'h08, 8'h88);
        stby(1'b0, 1'b0, 8'h00, 1);
        stby(1'b1, 1'b1, 8'h00, 2);
        stby(1'b1, 1'b1, 8'h06, 8);
    endtask : t_standby
    // pin release asks for standby only in the level-enable function
    task automatic t_trig(logic [1:0] f, logic e);
        int i;
        @(posedge clk);
        trigger_pin_function <= f;
        play_start           <= 1'b1;
        @(posedge clk);
        play_start      <= 1'b0;
        trigger_irq_pin <= 1'b0;
        // look only once the edge has settled, never in its own time step
        #1;
        chk("playing", playing, 1);
        for (i = 0; i < 8 && !in_standby; i++) begin
            @(posedge clk);
            #1;
        end
        chk("trig", in_standby, e);
        @(posedge clk);
        trigger_irq_pin <= 1'b1;
        repeat (4) @(posedge clk);
    endtask : t_trig
    task automatic conclude();
        $display("mismatches %0d of %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    // ----
    // main sequence
    // ----
    initial begin
        {reg_wr, reg_rd, play_start, sample_valid, idle_timeout, moving} = '0;
        {reg_addr, reg_wdata, sample, brk_len} = '0;
        trigger_pin_function = 2'h1;
        trigger_irq_pin = 1'b1;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_regs();
        t_open();
        t_hybrid();
        t_standby();
        wr(8'h08, 8'h80);
        t_trig(2'h0, 1'b0);
        t_trig(2'h1, 1'b1);
        conclude();
    end
endmodule : haptic_loop_brake_config_tb

// [verilog/haptic_loop_brake_config.sv]
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "haptic_cfg.svh"

module haptic_loop_brake_config
    import haptic_pkg::*;
#(
    parameter int SAMPLE_W     = `SAMPLE_W_DEF,
    parameter int SLOPE_THRESH = `SLOPE_THRESH_DEF
) (
    input  wire logic                       clk,
    input  wire logic                       rst,

    // register port
    input  wire logic [`CFG_ADDR_W-1:0]     reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [7:0]                 reg_rdata,

    // playback side
    input  wire logic                       play_start,
    input  wire logic                       sample_valid,
    input  wire logic signed [SAMPLE_W-1:0] sample,
    input  wire logic                       idle_timeout,
    input  wire logic                       motion_detect,
    input  wire logic                       brake_done,
    input  wire logic [1:0]                 trigger_pin_function,
    input  wire logic                       trigger_irq_pin,

    // drive control
    output logic                            actuator_type_sel,
    output logic                            closed_loop_drive,
    output logic                            openloop_brake,
    output logic                            standby_brake,
    output logic                            in_standby,
    output logic                            playing
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]  cfg;
        logic [7:0]  rdata;
        logic        trig_s1;
        logic        trig_s2;
        logic        trig_d;
        play_state_t st;
        logic        closed;
        logic        ol_brake;
        logic        stby_brake;
        logic        stby;
        logic        play;
    } ctl_state_t;

    ctl_state_t q_r;
    ctl_state_t q_nxt;

    logic step_valid;
    logic step_big;
    logic step_nonpos;

    // ----------------------------------------
    // slope and sign of each new sample
    // ----------------------------------------
    slope_check #(
        .SAMPLE_W     (SAMPLE_W),
        .SLOPE_THRESH (SLOPE_THRESH)
    ) u_slope (
        .clk           (clk),
        .rst           (rst),
        .sample_valid  (sample_valid),
        .sample        (sample),
        .step_valid_r  (step_valid),
        .step_big_r    (step_big),
        .step_nonpos_r (step_nonpos)
    );

    // ----------------------------------------
    // decoded configuration fields
    // ----------------------------------------
    logic open_sel;
    logic hybrid_sel;
    logic ol_autobrake;
    logic stby_brake_en;
    logic slope_en;
    logic cfg_hit;

    // fields act from the cycle after the write lands
    assign open_sel      = q_r.cfg[`FLD_OPEN_LOOP];
    assign hybrid_sel    = q_r.cfg[`FLD_HYBRID];
    assign ol_autobrake  = q_r.cfg[`FLD_OL_AUTOBRAKE];
    assign stby_brake_en = q_r.cfg[`FLD_STBY_BRAKE];
    // slope check only counts inside hybrid loop
    assign slope_en      = hybrid_sel & q_r.cfg[`FLD_SLOPE_CHECK];
    assign cfg_hit       = (reg_addr == `ACT_LOOP_CFG_OFF);

    // ----------------------------------------
    // standby request sources
    // ----------------------------------------
    logic trig_level_mode;
    logic trig_fall;
    logic stby_req;

    // the level enable only counts in function 1; other codes
    // leave the pin to pulse trigger or interrupt logic elsewhere
    assign trig_level_mode = (trigger_pin_function == `TRIG_FN_LEVEL_EN);
    assign trig_fall       = q_r.trig_d & ~q_r.trig_s2;
    assign stby_req        = idle_timeout | (trig_level_mode & trig_fall);

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        q_nxt = q_r;

        // pin sync, first stage feeds only the second
        q_nxt.trig_s1 = trigger_irq_pin;
        q_nxt.trig_s2 = q_r.trig_s1;
        q_nxt.trig_d  = q_r.trig_s2;

        // register write, all eight bits kept as written
        if (reg_wr && cfg_hit) begin
            q_nxt.cfg = reg_wdata;
        end

        // read data valid in the following cycle only;
        // unmapped addresses and idle cycles read zero
        q_nxt.rdata = 8'h00;
        if (reg_rd && cfg_hit) begin
            q_nxt.rdata = q_r.cfg;
        end

        // loop selection, decided per sample as it arrives
        if (step_valid) begin
            if (open_sel) begin
                // positive data stays open, the rest brakes closed only with ol_autobrake set
                q_nxt.closed   = ol_autobrake & step_nonpos;
                q_nxt.ol_brake = ol_autobrake & step_nonpos;
            end else if (slope_en) begin
                // hybrid with slope check: open unless big step
                q_nxt.closed   = step_big;
                q_nxt.ol_brake = 1'b0;
            end else begin
                // full closed loop, or hybrid without slope check
                q_nxt.closed   = 1'b1;
                q_nxt.ol_brake = 1'b0;
            end
        end

        // changing the loop field with no sample pending moves the drive
        // at once only into closed loop, plain hybrid or open without autobrake
        if (!step_valid && !open_sel && !slope_en) begin
            q_nxt.closed   = 1'b1;
            q_nxt.ol_brake = 1'b0;
        end
        if (!step_valid && open_sel && !ol_autobrake) begin
            q_nxt.closed   = 1'b0;
            q_nxt.ol_brake = 1'b0;
        end

        // playback sequencing into standby
        unique case (q_r.st)
            ST_IDLE: begin
                if (play_start) begin
                    q_nxt.st = ST_PLAY;
                end else if (stby_req) begin
                    q_nxt.st = ST_STANDBY;
                end
            end
            ST_PLAY: begin
                if (stby_req) begin
                    if (stby_brake_en) begin
                        q_nxt.st = ST_MOTION_CHECK;
                    end else begin
                        q_nxt.st = ST_STANDBY;
                    end
                end
            end
            ST_MOTION_CHECK: begin
                // a still actuator needs no brake pulse
                if (motion_detect) begin
                    q_nxt.st = ST_BRAKE;
                end else begin
                    q_nxt.st = ST_STANDBY;
                end
            end
            ST_BRAKE: begin
                // held until the drive loop reports the stop
                if (brake_done) begin
                    q_nxt.st = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (play_start) begin
                    q_nxt.st = ST_PLAY;
                end
            end
        endcase

        // outputs registered from the next state
        q_nxt.stby_brake = (q_nxt.st == ST_BRAKE);
        q_nxt.stby       = (q_nxt.st == ST_STANDBY);
        q_nxt.play       = (q_nxt.st == ST_PLAY);
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_r            <= '0;
            q_r.cfg        <= `ACT_LOOP_CFG_RST;
            q_r.st         <= ST_IDLE;
            q_r.closed     <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    // ----------------------------------------
    // outputs, all straight from the state register
    // ----------------------------------------
    assign reg_rdata         = q_r.rdata;
    // calibration reads this; host sets it first
    assign actuator_type_sel = q_r.cfg[`FLD_ACT_TYPE];
    assign closed_loop_drive = q_r.closed;
    assign openloop_brake    = q_r.ol_brake;
    assign standby_brake     = q_r.stby_brake;
    assign in_standby        = q_r.stby;
    assign playing           = q_r.play;

endmodule : haptic_loop_brake_config

// [verilog/slope_check.sv]
`timescale 1ns/1ps
`include "haptic_cfg.svh"

module slope_check
    import haptic_pkg::*;
#(
    parameter int SAMPLE_W     = `SAMPLE_W_DEF,
    parameter int SLOPE_THRESH = `SLOPE_THRESH_DEF
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       sample_valid,
    input  wire logic signed [SAMPLE_W-1:0] sample,
    output logic                            step_valid_r,
    output logic                            step_big_r,
    output logic                            step_nonpos_r
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic                       vld;
        logic                       big;
        logic                       nonpos;
        logic signed [SAMPLE_W-1:0] prev;
    } slope_state_t;

    localparam logic [SAMPLE_W:0] THRESH = (SAMPLE_W+1)'(SLOPE_THRESH);

    slope_state_t q_r;
    slope_state_t q_nxt;
    logic signed [SAMPLE_W:0] diff;
    logic        [SAMPLE_W:0] mag;

    // ----------------------------------------
    // step size against the previous sample
    // ----------------------------------------
    // one bit of headroom so full-scale swings cannot wrap
    assign diff = {sample[SAMPLE_W-1], sample} - {q_r.prev[SAMPLE_W-1], q_r.prev};
    assign mag  = diff[SAMPLE_W] ? (SAMPLE_W+1)'(-diff) : diff;

    // big, nonpos and prev update only on a new sample and hold between samples; vld follows sample_valid every cycle
    always_comb begin
        q_nxt     = q_r;
        q_nxt.vld = sample_valid;
        if (sample_valid) begin
            q_nxt.big    = (mag >= THRESH);
            q_nxt.nonpos = (sample <= 0);
            q_nxt.prev   = sample;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign step_valid_r  = q_r.vld;
    assign step_big_r    = q_r.big;
    assign step_nonpos_r = q_r.nonpos;

endmodule : slope_check
